/* File: verilog/shd_top.sv */
`timescale 1ns/1ps
module shd_top #(
  parameter int unsigned SAMP_CYC = shd_pkg::SAMP_OVF_CYCLES,
  parameter int unsigned DISP_CYC = shd_pkg::DISP_OVF_CYCLES,
  parameter int unsigned OVF_NUM  = shd_pkg::OVF_PER_INTERVAL
) (
  input  wire logic       mclk,
  input  wire logic       rst_n,
  input  wire logic       sensorConvDone,
  input  wire logic [9:0] sensorSampleData,
  output logic            sensorConvStart,
  output logic      [7:0] segmentLines,
  output logic            digitSelectBit0,
  output logic            digitSelectBit1
);

  localparam int unsigned SW = $clog2(SAMP_CYC);
  localparam int unsigned DW = $clog2(DISP_CYC);
  localparam int unsigned IW = $clog2(OVF_NUM);
  localparam logic [SW-1:0] SAMP_TOP = SW'(SAMP_CYC - 1);
  localparam logic [DW-1:0] DISP_TOP = DW'(DISP_CYC - 1);
  localparam logic [IW-1:0] INT_TOP  = IW'(OVF_NUM - 1);
  localparam logic [shd_pkg::POS_W-1:0] POS_BLANK = shd_pkg::POS_BLANK;

  logic [SW-1:0]                   sampCnt_ff;
  logic [DW-1:0]                   dispCnt_ff;
  logic [IW-1:0]                   intCnt_ff;
  logic [shd_pkg::NUM_TMR-1:0]     ovfFlag_ff;
  logic [shd_pkg::NUM_TMR-1:0]     readArm_ff;
  logic [shd_pkg::NUM_TMR-1:0]     timerOvf;
  logic [shd_pkg::NUM_TMR-1:0]     pollHit;
  shd_pkg::shd_state_t             state_ff;
  shd_pkg::shd_state_t             nxt_state;
  logic                            convStart_ff;
  logic                            doneSeen_ff;
  logic [shd_pkg::RESULT_W-1:0]    sampleHold_ff;
  logic [shd_pkg::RESULT_W-1:0]    result_ff;
  logic [shd_pkg::POS_W-1:0]       position_ff;
  logic [shd_pkg::SEG_W-1:0]       segments_ff;
  logic [shd_pkg::SEG_W-1:0]       nxt_segments;
  logic [shd_pkg::POS_W-1:0]       nxt_position;
  logic [shd_pkg::HEX_W-1:0]       hexValue;
  logic [shd_pkg::NIBBLE_W-1:0]    nibble [shd_pkg::NUM_DIGITS];
  logic [shd_pkg::NIBBLE_W-1:0]    selNibble;
  logic                            intWrap;
  logic                            latchNow;
  logic                            nxtBlank;

  ////////////////////////////////////////////////////////////////////////////
  // Free-running timers, overflow at the top count
  assign timerOvf[shd_pkg::TMR_SAMP] = (sampCnt_ff == SAMP_TOP);
  assign timerOvf[shd_pkg::TMR_DISP] = (dispCnt_ff == DISP_TOP);

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sampCnt_ff <= '0;
      dispCnt_ff <= '0;
    end else begin
      sampCnt_ff <= timerOvf[shd_pkg::TMR_SAMP] ? '0 : sampCnt_ff + 1'b1;
      dispCnt_ff <= timerOvf[shd_pkg::TMR_DISP] ? '0 : dispCnt_ff + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Overflow flags: set on overflow, read while set, then cleared
  generate
    for (genvar t = 0; t < shd_pkg::NUM_TMR; t++) begin : g_flag
      // Poll sees the flag set and arms the zero write
      assign pollHit[t] = ovfFlag_ff[t] & ~readArm_ff[t];

      always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
          ovfFlag_ff[t] <= 1'b0;
          readArm_ff[t] <= 1'b0;
        end else begin
          // New overflow wins over the clearing write
          ovfFlag_ff[t] <= timerOvf[t] | (ovfFlag_ff[t] & ~readArm_ff[t]);
          readArm_ff[t] <= pollHit[t];
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Sampling sequencer, leaves WAIT and CONV only on polls of the sampling flag
  assign intWrap  = pollHit[shd_pkg::TMR_SAMP] & (intCnt_ff == INT_TOP);
  assign latchNow = pollHit[shd_pkg::TMR_SAMP] & ~intWrap
                  & (state_ff == shd_pkg::SHD_ST_CONV) & doneSeen_ff;

  // Next state
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      shd_pkg::SHD_ST_WAIT: begin
        if (intWrap) begin
          nxt_state = shd_pkg::SHD_ST_START;
        end
      end
      shd_pkg::SHD_ST_START: begin
        nxt_state = shd_pkg::SHD_ST_CONV;
      end
      shd_pkg::SHD_ST_CONV: begin
        if (intWrap) begin
          nxt_state = shd_pkg::SHD_ST_START;
        end else if (latchNow) begin
          nxt_state = shd_pkg::SHD_ST_WAIT;
        end
      end
      default: begin
        nxt_state = shd_pkg::SHD_ST_WAIT;
      end
    endcase
  end

  // Interval counter and state
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff  <= shd_pkg::SHD_ST_WAIT;
      intCnt_ff <= '0;
    end else begin
      state_ff <= nxt_state;
      if (pollHit[shd_pkg::TMR_SAMP]) begin
        intCnt_ff <= intWrap ? '0 : intCnt_ff + 1'b1;
      end
    end
  end

  // Start pulse, done capture and result
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      convStart_ff  <= 1'b0;
      doneSeen_ff   <= 1'b0;
      sampleHold_ff <= shd_pkg::RESULT_RST;
      result_ff     <= shd_pkg::RESULT_RST;
    end else begin
      convStart_ff <= (state_ff == shd_pkg::SHD_ST_START);
      // Done wins over the clear
      doneSeen_ff  <= sensorConvDone | (doneSeen_ff & ~latchNow
                      & (state_ff != shd_pkg::SHD_ST_START));
      if (sensorConvDone) begin
        sampleHold_ff <= sensorSampleData;
      end
      if (latchNow) begin
        result_ff <= sampleHold_ff;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Hex digits, lowest digit on the first position
  assign hexValue = {{(shd_pkg::HEX_W - shd_pkg::RESULT_W){1'b0}}, result_ff};

  generate
    for (genvar d = 0; d < shd_pkg::NUM_DIGITS; d++) begin : g_nib
      assign nibble[d] = hexValue[d*shd_pkg::NIBBLE_W +: shd_pkg::NIBBLE_W];
    end
  endgenerate

  assign nxt_position = position_ff + 1'b1;
  assign nxtBlank     = (nxt_position == POS_BLANK);
  assign selNibble    = nxtBlank ? '0 : nibble[nxt_position];

  // Segment pattern for the position about to light
  shd_seg_decode shd_seg_decode_i (
    .hexDigit (selNibble),
    .blank    (nxtBlank),
    .segments (nxt_segments)
  );

  // Position and segment lines change together on each display poll
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      position_ff <= POS_BLANK;
      segments_ff <= shd_pkg::SEG_BLANK;
    end else if (pollHit[shd_pkg::TMR_DISP]) begin
      position_ff <= nxt_position;
      segments_ff <= nxt_segments;
    end
  end

  // Outputs straight from flops
  assign sensorConvStart = convStart_ff;
  assign segmentLines    = segments_ff;
  assign digitSelectBit0 = position_ff[0];
  assign digitSelectBit1 = position_ff[1];

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  property p_start_on_interval;
    @(posedge mclk) disable iff (!rst_n)
    $rose(sensorConvStart) |-> $past(intWrap, 2);
  endproperty
  a_start_on_interval: assert property (p_start_on_interval)
    else $error("conversion start not on interval wrap");

  property p_samp_ovf;
    @(posedge mclk) disable iff (!rst_n)
    (sampCnt_ff == SAMP_TOP) |=> (sampCnt_ff == '0) && ovfFlag_ff[shd_pkg::TMR_SAMP];
  endproperty
  a_samp_ovf: assert property (p_samp_ovf)
    else $error("sampling overflow missed");

  property p_digit_value;
    @(posedge mclk) disable iff (!rst_n)
    (pollHit[shd_pkg::TMR_DISP] && nxt_position == 2'h0)
      |=> segmentLines == shd_pkg::SEG_TABLE[$past(result_ff[3:0])];
  endproperty
  a_digit_value: assert property (p_digit_value)
    else $error("first position shows wrong digit");

  property p_select_order;
    @(posedge mclk) disable iff (!rst_n)
    pollHit[shd_pkg::TMR_DISP]
      |=> {digitSelectBit1, digitSelectBit0} == $past(position_ff) + 2'h1;
  endproperty
  a_select_order: assert property (p_select_order)
    else $error("display position out of order");

  property p_select_stable;
    @(posedge mclk) disable iff (!rst_n)
    !pollHit[shd_pkg::TMR_DISP] |=> $stable(position_ff) && $stable(segmentLines);
  endproperty
  a_select_stable: assert property (p_select_stable)
    else $error("select or segments moved between advances");

  property p_blank_fourth;
    @(posedge mclk) disable iff (!rst_n)
    (position_ff == POS_BLANK) |-> segmentLines == shd_pkg::SEG_BLANK;
  endproperty
  a_blank_fourth: assert property (p_blank_fourth)
    else $error("fourth position not dark");

  property p_result_on_poll;
    @(posedge mclk) disable iff (!rst_n)
    !$stable(result_ff) |-> $past(pollHit[shd_pkg::TMR_SAMP]) && $past(doneSeen_ff);
  endproperty
  a_result_on_poll: assert property (p_result_on_poll)
    else $error("result changed without a flag poll");

  property p_flag_clear;
    @(posedge mclk) disable iff (!rst_n)
    $fell(ovfFlag_ff[shd_pkg::TMR_DISP]) |-> $past(readArm_ff[shd_pkg::TMR_DISP]);
  endproperty
  a_flag_clear: assert property (p_flag_clear)
    else $error("display flag cleared without prior read");

  property p_flag_set_wins;
    @(posedge mclk) disable iff (!rst_n)
    timerOvf[shd_pkg::TMR_DISP] |=> ovfFlag_ff[shd_pkg::TMR_DISP] ##1 readArm_ff[shd_pkg::TMR_DISP];
  endproperty
  a_flag_set_wins: assert property (p_flag_set_wins)
    else $error("display overflow lost");

endmodule

/* File: verilog/shd_pkg.sv */
package shd_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Clock and timing
  localparam int unsigned CLK_PERIOD_NS      = 50;
  // Sampling timer overflow period, 32.768 ms
  localparam int unsigned SAMP_OVF_PERIOD_NS = 32768000;
  localparam int unsigned SAMP_OVF_CYCLES    = SAMP_OVF_PERIOD_NS / CLK_PERIOD_NS;
  // Sampling interval, 0.49152 s
  localparam int unsigned SAMP_INTERVAL_US   = 491520;
  localparam int unsigned OVF_PER_INTERVAL   = (SAMP_INTERVAL_US * 1000) / SAMP_OVF_PERIOD_NS;
  // Display timer overflow period, 2.048 ms
  localparam int unsigned DISP_OVF_PERIOD_NS = 2048000;
  localparam int unsigned DISP_OVF_CYCLES    = DISP_OVF_PERIOD_NS / CLK_PERIOD_NS;

  ////////////////////////////////////////////////////////////////////////////
  // Widths and field positions
  localparam int unsigned RESULT_W   = 10;
  localparam int unsigned SEG_W      = 8;
  localparam int unsigned POS_W      = 2;
  localparam int unsigned NUM_DIGITS = 3;
  localparam int unsigned NIBBLE_W   = 4;
  localparam int unsigned HEX_W      = NUM_DIGITS * NIBBLE_W;
  localparam int unsigned TMR_SAMP   = 0;
  localparam int unsigned TMR_DISP   = 1;
  localparam int unsigned NUM_TMR    = 2;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values and codes
  localparam logic [RESULT_W-1:0] RESULT_RST = 10'h000;
  localparam logic [SEG_W-1:0]    SEG_BLANK  = 8'h00;
  localparam logic [POS_W-1:0]    POS_RST    = 2'h0;
  localparam logic [POS_W-1:0]    POS_BLANK  = 2'h3;

  // Segment pattern per hex digit, bit 0 is segment a
  localparam logic [SEG_W-1:0] SEG_TABLE [16] = '{
    8'h3F, 8'h06, 8'h5B, 8'h4F, 8'h66, 8'h6D, 8'h7D, 8'h27,
    8'h7F, 8'h6F, 8'h77, 8'h7C, 8'h39, 8'h5E, 8'h79, 8'h71
  };

  // Sampling sequencer states, one bit changes on each step except CONV to WAIT
  typedef enum logic [1:0] {
    SHD_ST_WAIT  = 2'b00,
    SHD_ST_START = 2'b01,
    SHD_ST_CONV  = 2'b11
  } shd_state_t;

endpackage

/* File: verilog/shd_seg_decode.sv */
`timescale 1ns/1ps
module shd_seg_decode (
  input  wire logic [3:0] hexDigit,
  input  wire logic       blank,
  output logic      [7:0] segments
);

  // Table lookup, dark when blanked
  assign segments = blank ? shd_pkg::SEG_BLANK : shd_pkg::SEG_TABLE[hexDigit];

endmodule

/* File: tb/shd_led_model.sv */
`timescale 1ns/1ps
module shd_led_model (
  input  wire logic        mclk,
  input  wire logic [7:0]  segmentLines,
  input  wire logic        digitSelectBit0,
  input  wire logic        digitSelectBit1,
  output logic      [31:0] litDigits
);
  logic [3:0] enableN;
  logic [7:0] cathodes;

  ////////////////////////////////////////////////////////////////////////////
  // Decoder gives one active-low enable per position
  assign enableN  = ~(4'h1 << {digitSelectBit1, digitSelectBit0});
  // Inverting driver pulls a cathode low for a high line
  assign cathodes = ~segmentLines;

  ////////////////////////////////////////////////////////////////////////////
  // Remember what each enabled position lights
  always_ff @(posedge mclk) begin
    for (int p = 0; p < 4; p++) begin
      if (!enableN[p]) begin
        litDigits[p*8 +: 8] <= ~cathodes;
      end
    end
  end
endmodule

/* File: tb/sensor_sample_hex_display_bench.sv */
`timescale 1ns/1ps
module sensor_sample_hex_display_bench;
  localparam int unsigned SAMP = 40;
  localparam int unsigned DISP = 16;
  localparam int unsigned NOVF = 3;
  typedef struct packed {
    logic [9:0]  sample;
    logic [23:0] segs;
  } shd_row_t;
  logic        mclk;
  logic        rst_n;
  logic        sensorConvDone;
  logic [9:0]  sensorSampleData;
  logic        sensorConvStart;
  logic [7:0]  segmentLines;
  logic        digitSelectBit0;
  logic        digitSelectBit1;
  logic [31:0] litDigits;
  logic [1:0]  lastSel;
  int          badCount;
  int          checksDone;
  int          gap;
  shd_row_t    rows [10];

  ////////////////////////////////////////////////////////////////////////////
  shd_top #(.SAMP_CYC(SAMP), .DISP_CYC(DISP), .OVF_NUM(NOVF)) shd_top_i (
    .mclk(mclk), .rst_n(rst_n), .sensorConvDone(sensorConvDone),
    .sensorSampleData(sensorSampleData), .sensorConvStart(sensorConvStart),
    .segmentLines(segmentLines), .digitSelectBit0(digitSelectBit0),
    .digitSelectBit1(digitSelectBit1));
  shd_led_model shd_led_model_i (
    .mclk(mclk), .segmentLines(segmentLines), .digitSelectBit0(digitSelectBit0),
    .digitSelectBit1(digitSelectBit1), .litDigits(litDigits));

  // Clock, 50 ns period
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Compare and count
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] want);
    checksDone++;
    if (seen !== want) begin
      badCount++;
      $display("[ERR] %s expected %h seen %h", what, want, seen);
    end
  endtask

  // Verdict and end of run
  task automatic closeOut;
    $display("checks %0d mismatches %0d", checksDone, badCount);
    if (badCount == 0 && checksDone > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Wait for a start pulse, bounded
  task automatic waitStart(output int n);
    n = 0;
    do begin
      @(negedge mclk);
      n++;
    end while (sensorConvStart !== 1'b1 && n < 400);
    check("start seen", 32'(n < 400), 32'h1);
  endtask

  // Converter answers three cycles after start
  task automatic answer(input logic [9:0] value);
    @(negedge mclk);
    check("start width", 32'(sensorConvStart), 32'h0);
    repeat (2) @(negedge mclk);
    sensorConvDone = 1'b1;
    sensorSampleData = value;
    @(negedge mclk);
    sensorConvDone = 1'b0;
    sensorSampleData = ~value; // Data no longer held after done
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    rst_n = 1'b0;
    sensorConvDone = 1'b0;
    sensorSampleData = 10'h155;
    badCount = 0;
    checksDone = 0;
    rows = '{'{10'h000, 24'h3F3F3F}, '{10'h3FF, 24'h4F7171}, '{10'h010, 24'h3F063F},
             '{10'h132, 24'h064F5B}, '{10'h254, 24'h5B6D66}, '{10'h376, 24'h4F277D},
             '{10'h098, 24'h3F6F7F}, '{10'h1BA, 24'h067C77}, '{10'h2DC, 24'h5B5E39},
             '{10'h3FE, 24'h4F7179}};
    repeat (2) @(negedge mclk);
    check("reset segments", 32'(segmentLines), 32'h0);
    check("reset select", 32'({digitSelectBit1, digitSelectBit0}), 32'h3);
    rst_n = 1'b1;
    // Each row: convert, then see the three digit positions lit and the fourth dark
    for (int i = 0; i <= 10; i++) begin
      waitStart(gap);
      if (i == 0) begin
        check("first gap", gap, SAMP * NOVF + 2);
      end
      if (i > 0) begin
        check("start gap", gap, SAMP * NOVF - 4);
        check("lit digits", litDigits, {8'h00, rows[i-1].segs});
      end
      if (i < 10) begin
        answer(rows[i].sample);
      end
    end
    // Positions step in order, one per display period
    lastSel = {digitSelectBit1, digitSelectBit0};
    for (int k = 0; k < 5; k++) begin
      gap = 0;
      do begin
        @(negedge mclk);
        gap++;
      end while ({digitSelectBit1, digitSelectBit0} == lastSel && gap < 100);
      if (k > 0) begin
        check("advance gap", gap, DISP);
      end
      check("select order", 32'({digitSelectBit1, digitSelectBit0}),
            32'(2'(lastSel + 2'h1)));
      lastSel = {digitSelectBit1, digitSelectBit0};
    end
    // Reset in mid-run, then a conversion that never completes
    rst_n = 1'b0;
    @(negedge mclk);
    check("midrun segments", 32'(segmentLines), 32'h0);
    check("midrun select", 32'({digitSelectBit1, digitSelectBit0}), 32'h3);
    check("midrun start", 32'(sensorConvStart), 32'h0);
    rst_n = 1'b1;
    waitStart(gap);
    check("midrun first gap", gap, SAMP * NOVF + 2);
    check("cleared result", litDigits, 32'h003F3F3F);
    waitStart(gap);
    check("restart gap", gap, SAMP * NOVF);
    check("kept result", litDigits, 32'h003F3F3F);
    closeOut();
  end

  // Watchdog against a hang
  initial begin
    repeat (4000) @(posedge mclk);
    badCount++;
    closeOut();
  end
endmodule
